// file: verilog/evmon_top.sv
// Per-thread event monitor unit with shared timestamp counter
//
// Overview of operation
// - Each hardware thread owns two counters and two selectors.
// - Counters are 40 bits, at addresses 0x20 and 0x21.
// - Selectors are 32 bits, at addresses 0x28 and 0x29.
// - Counter read works at any privilege; selector 0 or 1, zero-extended.
// - Preference instruction at any privilege; operand bit clears or sets preference.
// - Preference instruction accepted only in 64-bit mode.
// - Preference only records a wish; privileged control picks affected counters.
// - Preference control register at 0x2C permits preference gating.
// - Config reads and writes only at privilege zero, 64-bit data.
// - Time read at any privilege, answers in four to five cycles.
// - Timestamp counters stay synchronized across all cores.
// - Overflow status at 0x2D, sticky bit per counter.
// - Writing ones to 0x2E clears matching overflow bits.
// - Master enable at 0x2F gates all event counting.
// - Timestamp keeps running regardless of master enable.
`timescale 1ns/1ps
`default_nettype none
module evmon_top #(
  parameter int NUM_THREADS = evmon_pkg::NUM_THREADS,
  parameter int EVT_W = 256
) (
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic REQ_VALID_IN,
  input wire logic [1:0] REQ_OP_IN,
  input wire logic [evmon_pkg::THR_W-1:0] REQ_THREAD_IN,
  input wire logic [1:0] REQ_PRIV_IN,
  input wire logic [31:0] SELECTOR_GPR_IN,
  input wire logic [63:0] RESULT_GPR_PAIR_IN,
  input wire logic PREF_VALID_IN,
  input wire logic [evmon_pkg::THR_W-1:0] PREF_THREAD_IN,
  input wire logic PREF_OPERAND_IN,
  input wire logic MODE64_IN,
  input wire logic TS_SYNC_IN,
  input wire logic [63:0] TS_SYNC_VALUE_IN,
  input wire logic [NUM_THREADS*EVT_W-1:0] EVENTS_IN,
  output logic REQ_READY_OUT,
  output logic RESP_VALID_OUT,
  output logic RESP_FAULT_OUT,
  output logic [63:0] RESULT_GPR_PAIR_OUT,
  output logic PREF_FAULT_OUT,
  output logic [63:0] TIMESTAMP_OUT
);
  localparam logic [2:0] TS_WAIT = 3'(evmon_pkg::TS_READ_CYCLES - 1);

  evmon_pkg::state_t state_r, state_nxt;
  logic [2:0] wait_r, wait_nxt;
  logic [63:0] ts_r, ts_nxt;
  logic [63:0] res_r, res_nxt;
  logic fault_nxt;
  logic pfault_nxt;
  logic [NUM_THREADS-1:0] twr;
  logic [NUM_THREADS-1:0] tpref;
  logic [evmon_pkg::CNT_W-1:0] c0 [NUM_THREADS];
  logic [evmon_pkg::CNT_W-1:0] c1 [NUM_THREADS];
  logic [31:0] s0 [NUM_THREADS];
  logic [31:0] s1 [NUM_THREADS];
  logic [63:0] pr [NUM_THREADS];
  logic [1:0] ov [NUM_THREADS];
  logic [1:0] me [NUM_THREADS];
  logic take;
  logic cfg_ok;
  logic ts_wr;

  // Request taken only while ready is shown, so none slips in right after reset
  assign take = REQ_VALID_IN && REQ_READY_OUT;
  assign cfg_ok = REQ_PRIV_IN == 2'h0;
  assign ts_wr = take && cfg_ok && REQ_OP_IN == evmon_pkg::OP_CFG_WRITE &&
                 SELECTOR_GPR_IN == evmon_pkg::ADDR_TIMESTAMP;

  // Write strobes per thread
  always_comb begin
    for (int t = 0; t < NUM_THREADS; t++) begin
      twr[t] = take && cfg_ok && REQ_OP_IN == evmon_pkg::OP_CFG_WRITE &&
               REQ_THREAD_IN == evmon_pkg::THR_W'(t);
      tpref[t] = PREF_VALID_IN && MODE64_IN &&
                 PREF_THREAD_IN == evmon_pkg::THR_W'(t);
    end
  end

  // Private thread state
  genvar g;
  generate
    for (g = 0; g < NUM_THREADS; g++) begin : g_thr
      evmon_thread #(.EVT_W(EVT_W)) u_thr (
        .clk_in(CLK_IN),
        .reset_n_in(RESET_N_IN),
        .events_in(EVENTS_IN[g*EVT_W +: EVT_W]),
        .wr_in(twr[g]),
        .addr_in(SELECTOR_GPR_IN),
        .wdata_in(RESULT_GPR_PAIR_IN),
        .pref_wr_in(tpref[g]),
        .pref_val_in(PREF_OPERAND_IN),
        .cnt0_out(c0[g]),
        .cnt1_out(c1[g]),
        .sel0_out(s0[g]),
        .sel1_out(s1[g]),
        .pref_out(pr[g]),
        .ovf_out(ov[g]),
        .men_out(me[g])
      );
    end
  endgenerate

  // Timestamp: free running, loaded by chip sync or config write
  always_comb begin
    ts_nxt = ts_r + 64'h1;
    if (TS_SYNC_IN) begin
      ts_nxt = TS_SYNC_VALUE_IN;
    end else if (ts_wr) begin
      ts_nxt = RESULT_GPR_PAIR_IN;
    end
  end

  // Request sequencer and read mux
  always_comb begin
    state_nxt = state_r;
    wait_nxt = wait_r;
    res_nxt = res_r;
    fault_nxt = 1'b0;
    pfault_nxt = PREF_VALID_IN && !MODE64_IN;
    case (state_r)
      evmon_pkg::ST_IDLE: begin
        if (take) begin
          state_nxt = evmon_pkg::ST_DONE;
          res_nxt = 64'h0;
          case (evmon_pkg::op_t'(REQ_OP_IN))
            evmon_pkg::OP_TIME_READ: begin
              state_nxt = evmon_pkg::ST_WAIT;
              wait_nxt = TS_WAIT;
              res_nxt = ts_r;
            end
            evmon_pkg::OP_EVT_READ: begin
              if (SELECTOR_GPR_IN == evmon_pkg::SEL_COUNT0) begin
                res_nxt = {24'h0, c0[REQ_THREAD_IN]};
              end else if (SELECTOR_GPR_IN == evmon_pkg::SEL_COUNT1) begin
                res_nxt = {24'h0, c1[REQ_THREAD_IN]};
              end else begin
                fault_nxt = 1'b1;
              end
            end
            evmon_pkg::OP_CFG_READ: begin
              if (!cfg_ok) begin
                fault_nxt = 1'b1;
              end else begin
                case (SELECTOR_GPR_IN)
                  evmon_pkg::ADDR_TIMESTAMP: res_nxt = ts_r;
                  evmon_pkg::ADDR_COUNT0: res_nxt = {24'h0, c0[REQ_THREAD_IN]};
                  evmon_pkg::ADDR_COUNT1: res_nxt = {24'h0, c1[REQ_THREAD_IN]};
                  evmon_pkg::ADDR_SELECT0: res_nxt = {32'h0, s0[REQ_THREAD_IN]};
                  evmon_pkg::ADDR_SELECT1: res_nxt = {32'h0, s1[REQ_THREAD_IN]};
                  evmon_pkg::ADDR_PREF_CTRL: res_nxt = pr[REQ_THREAD_IN];
                  evmon_pkg::ADDR_OVF_STATUS: res_nxt = {62'h0, ov[REQ_THREAD_IN]};
                  evmon_pkg::ADDR_MASTER_EN: res_nxt = {62'h0, me[REQ_THREAD_IN]};
                  default: fault_nxt = 1'b1;
                endcase
              end
            end
            default: begin
              fault_nxt = !cfg_ok;
            end
          endcase
        end
      end
      evmon_pkg::ST_WAIT: begin
        wait_nxt = wait_r - 3'h1;
        if (wait_r == 3'h1) begin
          state_nxt = evmon_pkg::ST_DONE;
        end
      end
      evmon_pkg::ST_DONE: begin
        state_nxt = evmon_pkg::ST_IDLE;
      end
      default: state_nxt = evmon_pkg::ST_IDLE;
    endcase
  end

  // Register stage
  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      state_r <= evmon_pkg::ST_IDLE;
      wait_r <= 3'h0;
      ts_r <= evmon_pkg::TS_RST;
      res_r <= 64'h0;
      REQ_READY_OUT <= 1'b0;
      RESP_VALID_OUT <= 1'b0;
      RESP_FAULT_OUT <= 1'b0;
      RESULT_GPR_PAIR_OUT <= 64'h0;
      PREF_FAULT_OUT <= 1'b0;
      TIMESTAMP_OUT <= evmon_pkg::TS_RST;
    end else begin
      state_r <= state_nxt;
      wait_r <= wait_nxt;
      ts_r <= ts_nxt;
      res_r <= res_nxt;
      REQ_READY_OUT <= state_nxt == evmon_pkg::ST_IDLE;
      RESP_VALID_OUT <= state_nxt == evmon_pkg::ST_DONE;
      RESP_FAULT_OUT <= state_nxt == evmon_pkg::ST_DONE &&
                        (state_r == evmon_pkg::ST_IDLE ? fault_nxt : 1'b0);
      RESULT_GPR_PAIR_OUT <= (state_nxt == evmon_pkg::ST_DONE) ? res_nxt : 64'h0;
      PREF_FAULT_OUT <= pfault_nxt;
      TIMESTAMP_OUT <= ts_nxt;
    end
  end

  property p_ts_latency;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (take && REQ_OP_IN == evmon_pkg::OP_TIME_READ) |-> ##[4:5] RESP_VALID_OUT;
  endproperty
  a_ts_latency: assert property (p_ts_latency) else $error("time read latency");

  property p_ts_run;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (!TS_SYNC_IN && !ts_wr) |=> ts_r == $past(ts_r) + 64'h1;
  endproperty
  a_ts_run: assert property (p_ts_run) else $error("timestamp stalled");

  property p_priv;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (take && REQ_OP_IN == evmon_pkg::OP_CFG_READ && !cfg_ok) |=> RESP_FAULT_OUT;
  endproperty
  a_priv: assert property (p_priv) else $error("unprivileged config access");

  property p_evt_read;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (take && REQ_OP_IN == evmon_pkg::OP_EVT_READ && SELECTOR_GPR_IN == 32'h1)
      |=> RESP_VALID_OUT && RESULT_GPR_PAIR_OUT[63:40] == 24'h0 && !RESP_FAULT_OUT;
  endproperty
  a_evt_read: assert property (p_evt_read) else $error("counter read wrong");

  property p_mode64;
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (PREF_VALID_IN && !MODE64_IN) |=> PREF_FAULT_OUT;
  endproperty
  a_mode64: assert property (p_mode64) else $error("preference outside 64-bit");
endmodule
`default_nettype wire

// file: verilog/evmon_pkg.sv
// Package of addresses, field positions and timing for the event monitor unit
package evmon_pkg;
  localparam int NUM_THREADS = 4;
  localparam int CNT_W = 40;
  localparam int SEL_W = 32;
  localparam int THR_W = 2;
  localparam logic [31:0] ADDR_TIMESTAMP = 32'h0000_0010;
  localparam logic [31:0] ADDR_COUNT0 = 32'h0000_0020;
  localparam logic [31:0] ADDR_COUNT1 = 32'h0000_0021;
  localparam logic [31:0] ADDR_SELECT0 = 32'h0000_0028;
  localparam logic [31:0] ADDR_SELECT1 = 32'h0000_0029;
  localparam logic [31:0] ADDR_PREF_CTRL = 32'h0000_002c;
  localparam logic [31:0] ADDR_OVF_STATUS = 32'h0000_002d;
  localparam logic [31:0] ADDR_OVF_CLEAR = 32'h0000_002e;
  localparam logic [31:0] ADDR_MASTER_EN = 32'h0000_002f;
  localparam logic [31:0] SEL_COUNT0 = 32'h0000_0000;
  localparam logic [31:0] SEL_COUNT1 = 32'h0000_0001;
  // Selector field layout
  localparam int SEL_EN_BIT = 22;
  localparam int SEL_EVT_LSB = 0;
  localparam int SEL_EVT_W = 8;
  // Preference control field: per-counter permission bits, preference bit
  localparam int PREF_ALLOW_LSB = 0;
  localparam int PREF_BIT = 63;
  // Reset values
  localparam logic [63:0] TS_RST = 64'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 40'h0;
  localparam logic [SEL_W-1:0] SEL_RST = 32'h0;
  localparam logic [63:0] PREF_RST = 64'h0;
  localparam logic [1:0] MEN_RST = 2'h0;
  // Time-read latency in core cycles (4 to 5 allowed)
  localparam int TS_READ_CYCLES = 4;
  typedef enum logic [1:0] {
    OP_CFG_READ = 2'h0,
    OP_CFG_WRITE = 2'h1,
    OP_TIME_READ = 2'h2,
    OP_EVT_READ = 2'h3
  } op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b11
  } state_t;
endpackage

// file: verilog/evmon_thread.sv
// One thread's private counters, selectors, preference, status and enable
`timescale 1ns/1ps
`default_nettype none
module evmon_thread #(
  parameter int CNT_W = evmon_pkg::CNT_W,
  parameter int EVT_W = 256
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [EVT_W-1:0] events_in,
  input wire logic wr_in,
  input wire logic [31:0] addr_in,
  input wire logic [63:0] wdata_in,
  input wire logic pref_wr_in,
  input wire logic pref_val_in,
  output logic [CNT_W-1:0] cnt0_out,
  output logic [CNT_W-1:0] cnt1_out,
  output logic [31:0] sel0_out,
  output logic [31:0] sel1_out,
  output logic [63:0] pref_out,
  output logic [1:0] ovf_out,
  output logic [1:0] men_out
);
  logic [CNT_W-1:0] cnt_r [2];
  logic [CNT_W-1:0] cnt_nxt [2];
  logic [31:0] sel_r [2];
  logic [31:0] sel_nxt [2];
  logic [63:0] pref_r, pref_nxt;
  logic [1:0] ovf_r, ovf_nxt;
  logic [1:0] men_r, men_nxt;
  logic [1:0] inc;
  logic [1:0] wrap;

  // Next-state of all per-thread state
  always_comb begin
    pref_nxt = pref_r;
    men_nxt = men_r;
    ovf_nxt = ovf_r;
    for (int i = 0; i < 2; i++) begin
      logic [7:0] evn;
      logic allow;
      evn = sel_r[i][evmon_pkg::SEL_EVT_LSB +: evmon_pkg::SEL_EVT_W];
      // Preference gates a counter only where privileged control allows it
      allow = pref_r[evmon_pkg::PREF_ALLOW_LSB + i];
      inc[i] = men_r[i] && sel_r[i][evmon_pkg::SEL_EN_BIT] && events_in[evn] &&
               (!allow || pref_r[evmon_pkg::PREF_BIT]);
      wrap[i] = inc[i] && (cnt_r[i] == {CNT_W{1'b1}});
      cnt_nxt[i] = inc[i] ? cnt_r[i] + 1'b1 : cnt_r[i];
      sel_nxt[i] = sel_r[i];
    end
    if (wr_in) begin
      case (addr_in)
        evmon_pkg::ADDR_COUNT0: cnt_nxt[0] = wdata_in[CNT_W-1:0];
        evmon_pkg::ADDR_COUNT1: cnt_nxt[1] = wdata_in[CNT_W-1:0];
        evmon_pkg::ADDR_SELECT0: sel_nxt[0] = wdata_in[31:0];
        evmon_pkg::ADDR_SELECT1: sel_nxt[1] = wdata_in[31:0];
        evmon_pkg::ADDR_PREF_CTRL: pref_nxt = wdata_in;
        evmon_pkg::ADDR_OVF_CLEAR: ovf_nxt = ovf_r & ~wdata_in[1:0];
        evmon_pkg::ADDR_MASTER_EN: men_nxt = wdata_in[1:0];
        default: ;
      endcase
    end
    // Preference instruction only records the wish bit
    if (pref_wr_in) begin
      pref_nxt[evmon_pkg::PREF_BIT] = pref_val_in;
    end
    // Overflow set wins over a same-cycle clear
    ovf_nxt = ovf_nxt | wrap;
  end

  // Register stage
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cnt_r[0] <= evmon_pkg::CNT_RST;
      cnt_r[1] <= evmon_pkg::CNT_RST;
      sel_r[0] <= evmon_pkg::SEL_RST;
      sel_r[1] <= evmon_pkg::SEL_RST;
      pref_r <= evmon_pkg::PREF_RST;
      ovf_r <= 2'h0;
      men_r <= evmon_pkg::MEN_RST;
    end else begin
      cnt_r <= cnt_nxt;
      sel_r <= sel_nxt;
      pref_r <= pref_nxt;
      ovf_r <= ovf_nxt;
      men_r <= men_nxt;
    end
  end

  assign cnt0_out = cnt_r[0];
  assign cnt1_out = cnt_r[1];
  assign sel0_out = sel_r[0];
  assign sel1_out = sel_r[1];
  assign pref_out = pref_r;
  assign ovf_out = ovf_r;
  assign men_out = men_r;

  property p_ovf_sticky;
    @(posedge clk_in) disable iff (!reset_n_in)
      (ovf_r[0] && !(wr_in && addr_in == evmon_pkg::ADDR_OVF_CLEAR && wdata_in[0]))
      |=> ovf_r[0];
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow bit lost");

  property p_ovf_clear;
    @(posedge clk_in) disable iff (!reset_n_in)
      (wr_in && addr_in == evmon_pkg::ADDR_OVF_CLEAR && wdata_in[1] && !wrap[1])
      |=> !ovf_r[1];
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow not cleared");

  property p_master_stop;
    @(posedge clk_in) disable iff (!reset_n_in)
      (men_r == 2'h0 && !wr_in) |=> (cnt_r[0] == $past(cnt_r[0]));
  endproperty
  a_master_stop: assert property (p_master_stop) else $error("counted while disabled");

  property p_wrap;
    @(posedge clk_in) disable iff (!reset_n_in)
      (inc[0] && cnt_r[0] == {CNT_W{1'b1}} && !wr_in) |=> (cnt_r[0] == '0 && ovf_r[0]);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap failed");

  property p_pref;
    @(posedge clk_in) disable iff (!reset_n_in)
      pref_wr_in |=> (pref_r[evmon_pkg::PREF_BIT] == $past(pref_val_in));
  endproperty
  a_pref: assert property (p_pref) else $error("preference bit wrong");
endmodule
`default_nettype wire

// file: dv/per_thread_event_counters_tb.sv
// Self-checking bench for the per-thread event monitor unit
`timescale 1ns/1ps
`default_nettype none
module per_thread_event_counters_tb;
  localparam int EW = 256;
  localparam logic [31:0] C0 = evmon_pkg::ADDR_COUNT0;
  localparam logic [31:0] C1 = evmon_pkg::ADDR_COUNT1;
  localparam logic [31:0] S0 = evmon_pkg::ADDR_SELECT0;
  localparam logic [31:0] ST = evmon_pkg::ADDR_OVF_STATUS;
  localparam logic [31:0] PC = evmon_pkg::ADDR_PREF_CTRL;
  localparam logic [31:0] ME = evmon_pkg::ADDR_MASTER_EN;
  logic clk, rst_n, req_valid, pref_valid, pref_op, mode64, ts_sync;
  logic [1:0] req_op, req_priv;
  logic [evmon_pkg::THR_W-1:0] req_thr, pref_thr;
  logic [31:0] sel;
  logic [63:0] wdata, ts_val, result, tstamp, r;
  logic [evmon_pkg::NUM_THREADS*EW-1:0] events;
  logic ready, rvalid, rfault, pfault, f;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;
  int lat;

  evmon_top #(.NUM_THREADS(evmon_pkg::NUM_THREADS), .EVT_W(EW)) evmon_top_i (
    .CLK_IN(clk), .RESET_N_IN(rst_n), .REQ_VALID_IN(req_valid), .REQ_OP_IN(req_op),
    .REQ_THREAD_IN(req_thr), .REQ_PRIV_IN(req_priv), .SELECTOR_GPR_IN(sel),
    .RESULT_GPR_PAIR_IN(wdata), .PREF_VALID_IN(pref_valid), .PREF_THREAD_IN(pref_thr),
    .PREF_OPERAND_IN(pref_op), .MODE64_IN(mode64), .TS_SYNC_IN(ts_sync),
    .TS_SYNC_VALUE_IN(ts_val), .EVENTS_IN(events), .REQ_READY_OUT(ready),
    .RESP_VALID_OUT(rvalid), .RESP_FAULT_OUT(rfault), .RESULT_GPR_PAIR_OUT(result),
    .PREF_FAULT_OUT(pfault), .TIMESTAMP_OUT(tstamp)
  );

  // Core clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      $display("[ERR] %0t timeout", $time);
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // One request: held until taken, then wait for the response pulse
  task automatic op(input logic [1:0] o, input logic [1:0] th, input logic [1:0] pr,
                    input logic [31:0] s, input logic [63:0] w);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_op = o;
    req_thr = th;
    req_priv = pr;
    sel = s;
    wdata = w;
    // Ready seen just after an edge stands at the next edge, which takes the request
    while (ready !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    #1 req_valid = 1'b0;
    lat = 1;
    while (rvalid !== 1'b1 && lat < 20) begin
      @(posedge clk);
      #1 lat++;
    end
    if (rvalid !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t no response", $time);
    end
    f = rfault;
    r = result;
    // Let one edge pass so the next request is not raised in this time step
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [1:0] th, input logic [31:0] a, input logic [63:0] v);
    op(2'h1, th, 2'h0, a, v);
  endtask

  task automatic rd(input logic [1:0] th, input logic [31:0] a);
    op(2'h0, th, 2'h0, a, 64'h0);
  endtask

  // One-cycle event strobe for one thread
  task automatic ev(input int th, input int e);
    events[th*EW+e] = 1'b1;
    @(posedge clk);
    #1 events = '0;
    @(posedge clk);
    #1;
  endtask

  task automatic pf(input logic [1:0] th, input logic v);
    pref_valid = 1'b1;
    pref_thr = th;
    pref_op = v;
    @(posedge clk);
    #1 pref_valid = 1'b0;
    f = pfault;
  endtask

  task automatic t_regs();
    rd(0, C0);
    chk(r, 64'h0, "count0 reset");
    wr(1, C1, 64'hffff_ffff_ffff_ffff);
    rd(1, C1);
    chk(r, 64'h0000_00ff_ffff_ffff, "count1 width");
    wr(1, S0, 64'h1234_5678_9abc_def0);
    rd(1, S0);
    chk(r, 64'h0000_0000_9abc_def0, "select0 width");
    rd(0, S0);
    chk(r, 64'h0, "other thread select");
    rd(0, 32'h0000_0022);
    chk({63'h0, f}, 64'h1, "unmapped fault");
    op(2'h1, 0, 2'h3, evmon_pkg::ADDR_SELECT1, 64'h5);
    chk({63'h0, f}, 64'h1, "user write fault");
    rd(0, evmon_pkg::ADDR_SELECT1);
    chk(r, 64'h0, "user write ignored");
    $display("test regs done");
  endtask

  task automatic t_evread();
    op(2'h3, 1, 2'h3, evmon_pkg::SEL_COUNT1, 64'h0);
    chk(r, 64'h0000_00ff_ffff_ffff, "event read 1");
    chk({63'h0, f}, 64'h0, "event read no fault");
    chk(lat, 1, "event read latency");
    op(2'h3, 1, 2'h3, evmon_pkg::SEL_COUNT0, 64'h0);
    chk(r, 64'h0, "event read 0");
    op(2'h3, 1, 2'h3, 32'h0000_0002, 64'h0);
    chk({63'h0, f}, 64'h1, "bad selector");
    $display("test evread done");
  endtask

  task automatic t_count();
    wr(2, S0, 64'h0000_0000_0040_0005);
    wr(2, ME, 64'h1);
    repeat (3) ev(2, 5);
    ev(2, 6);
    ev(3, 5);
    rd(2, C0);
    chk(r, 64'h3, "count three");
    rd(3, C0);
    chk(r, 64'h0, "other thread idle");
    wr(2, ME, 64'h0);
    ev(2, 5);
    rd(2, C0);
    chk(r, 64'h3, "master off holds");
    $display("test count done");
  endtask

  task automatic t_ovf();
    wr(2, ME, 64'h1);
    wr(2, C0, 64'h0000_00ff_ffff_ffff);
    ev(2, 5);
    rd(2, C0);
    chk(r, 64'h0, "wrap to zero");
    rd(2, ST);
    chk(r, 64'h1, "overflow set");
    ev(2, 5);
    rd(2, ST);
    chk(r, 64'h1, "overflow sticky");
    wr(2, evmon_pkg::ADDR_OVF_CLEAR, 64'h2);
    rd(2, ST);
    chk(r, 64'h1, "clear other bit");
    wr(2, evmon_pkg::ADDR_OVF_CLEAR, 64'h1);
    rd(2, ST);
    chk(r, 64'h0, "clear bit0");
    $display("test ovf done");
  endtask

  task automatic t_pref();
    wr(2, PC, 64'h1);
    wr(2, C0, 64'h0);
    ev(2, 5);
    rd(2, C0);
    chk(r, 64'h0, "gated by preference");
    pf(2, 1'b1);
    chk({63'h0, f}, 64'h0, "pref accepted");
    rd(2, PC);
    chk(r, 64'h8000_0000_0000_0001, "pref set");
    ev(2, 5);
    rd(2, C0);
    chk(r, 64'h1, "pref enables");
    mode64 = 1'b0;
    pf(2, 1'b0);
    chk({63'h0, f}, 64'h1, "pref outside mode");
    mode64 = 1'b1;
    rd(2, PC);
    chk(r, 64'h8000_0000_0000_0001, "pref kept");
    pf(2, 1'b0);
    rd(2, PC);
    chk(r, 64'h1, "pref cleared");
    $display("test pref done");
  endtask

  task automatic t_time();
    ts_val = 64'h0000_0100_0000_0000;
    ts_sync = 1'b1;
    @(posedge clk);
    #1 ts_sync = 1'b0;
    chk(tstamp, ts_val, "sync load");
    repeat (10) @(posedge clk);
    #1 chk(tstamp, ts_val + 64'd10, "free run");
    op(2'h2, 0, 2'h3, 32'h0, 64'h0);
    chk(lat, evmon_pkg::TS_READ_CYCLES, "time latency");
    chk({63'h0, f}, 64'h0, "time no fault");
    chk({63'h0, r >= ts_val + 64'd10 && r <= ts_val + 64'd11}, 64'h1, "time value");
    $display("test time done");
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_op = 2'h0;
    req_thr = '0;
    req_priv = 2'h0;
    sel = 32'h0;
    wdata = 64'h0;
    pref_valid = 1'b0;
    pref_thr = '0;
    pref_op = 1'b0;
    mode64 = 1'b1;
    ts_sync = 1'b0;
    ts_val = 64'h0;
    events = '0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    t_regs();
    t_evread();
    t_count();
    t_ovf();
    t_pref();
    t_time();
    complete_run();
  end
endmodule
`default_nettype wire
